/* File: include/adc_readout_pkg.sv */
package adc_readout_pkg;
	localparam int RESULT_W    = 16;
	localparam int ENABLE_EDGE = 5;
	localparam logic [RESULT_W-1:0] CODE_MAX = 16'hFFFF;
	localparam logic [RESULT_W-1:0] CODE_MIN = 16'h0000;

	// Conversion sample as handed in by the analog side
	typedef struct packed {
		logic                       over;
		logic                       under;
		logic [RESULT_W-1:0]        code;
	} sample_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SHIFT,
		ST_DONE
	} phase_t;
endpackage

/* File: hw/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module pin_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic pinIn,
	input  wire logic initVal,
	output logic      level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	// First stage feeds only the second
	// Reset fills every stage with the pin's idle level, so no false edge follows
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s1_r    <= initVal;
			s2_r    <= initVal;
			s3_r    <= initVal;
			level_r <= initVal;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				level_r <= s3_r;
			end
		end
	end

	assign level = level_r;
endmodule
`default_nettype wire

/* File: hw/adc_serial_readout.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Output stays off until fifth clock fall, then enabled driving low.
// - Result shifts out MSB first, one bit per following clock fall.
// - Each bit stays valid across both edges of its clock period.
// - Device powers down automatically when the shift phase ends or select rises.
// - Result is 16-bit straight binary, saturating at FFFF and 0000.
// - Shifted data belongs to the sample taken at that same select edge.
// - Analog input is held at the select falling edge.
module adc_serial_readout
	import adc_readout_pkg::*;
#(
	parameter int WIDTH = RESULT_W
) (
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire logic            selectN,
	input  wire logic            serial_clock_in,
	input  wire sample_t         sampleIn,
	output logic                 dataOut,
	output logic                 dataOe,
	output logic                 holdSample,
	output logic                 powerDown
);
	localparam logic [2:0]       EDGE_CNT = 3'(ENABLE_EDGE);
	localparam int               CNT_W    = $clog2(WIDTH + 1);
	// Bit count follows WIDTH; the captured word keeps the package width
	localparam logic [CNT_W-1:0] BIT_CNT  = CNT_W'(WIDTH);

	logic                selLvl;
	logic                sclkLvl;
	logic                selPrev_r;
	logic                sclkPrev_r;
	phase_t              state_r;
	phase_t              state_nxt;
	logic [2:0]          edgeCnt_r;
	logic [2:0]          edgeCnt_nxt;
	logic [CNT_W-1:0]    bitCnt_r;
	logic [CNT_W-1:0]    bitCnt_nxt;
	logic [RESULT_W-1:0] shift_r;
	logic [RESULT_W-1:0] shift_nxt;
	logic                dataOut_r;
	logic                dataOut_nxt;
	logic                dataOe_r;
	logic                dataOe_nxt;
	logic                hold_r;
	logic                hold_nxt;

	pin_sync uSel (
		.clk     (clk),
		.resetn  (resetn),
		.pinIn   (selectN),
		.initVal (1'b1),
		.level   (selLvl)
	);
	pin_sync uSclk (
		.clk     (clk),
		.resetn  (resetn),
		.pinIn   (serial_clock_in),
		.initVal (1'b0),
		.level   (sclkLvl)
	);

	// Edge detection on synchronised levels
	wire selFall  = selPrev_r & ~selLvl;
	wire selRise  = ~selPrev_r & selLvl;
	wire sclkFall = sclkPrev_r & ~sclkLvl;

	// Counter end points of the wait and shift phases
	wire lastWait = edgeCnt_r == EDGE_CNT - 3'h1;
	wire lastBit  = bitCnt_r == BIT_CNT - CNT_W'(1);

	// Saturate out-of-range inputs to the end codes
	function automatic logic [RESULT_W-1:0] clampCode(input sample_t s);
		if (s.over) begin
			clampCode = CODE_MAX;
		end else if (s.under) begin
			clampCode = CODE_MIN;
		end else begin
			clampCode = s.code;
		end
	endfunction

	wire [RESULT_W-1:0] capCode = clampCode(sampleIn);

	// Edge history; reset assumes select idle high
	always_ff @(posedge clk) begin
		if (!resetn) begin
			selPrev_r  <= 1'b1;
			sclkPrev_r <= 1'b0;
		end else begin
			selPrev_r  <= selLvl;
			sclkPrev_r <= sclkLvl;
		end
	end

	// Transfer sequencer; select rising aborts at any point
	// A frame cut mid-shift simply loses its remaining bits
	always_comb begin
		state_nxt   = state_r;
		edgeCnt_nxt = edgeCnt_r;
		bitCnt_nxt  = bitCnt_r;
		shift_nxt   = shift_r;
		dataOut_nxt = dataOut_r;
		dataOe_nxt  = dataOe_r;
		hold_nxt    = hold_r;
		if (selRise) begin
			state_nxt  = ST_IDLE;
			dataOe_nxt = 1'h0;
			hold_nxt   = 1'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (selFall) begin
						shift_nxt   = capCode;
						hold_nxt    = 1'h1;
						edgeCnt_nxt = 3'h0;
						bitCnt_nxt  = '0;
						state_nxt   = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (sclkFall) begin
						edgeCnt_nxt = edgeCnt_r + 3'h1;
						if (lastWait) begin
							dataOe_nxt  = 1'h1;
							dataOut_nxt = 1'h0;
							state_nxt   = ST_SHIFT;
						end
					end
				end
				ST_SHIFT: begin
					// Bit changes only on a fall, so it spans a whole period
					if (sclkFall) begin
						dataOut_nxt = shift_r[RESULT_W-1];
						shift_nxt   = {shift_r[RESULT_W-2:0], 1'h0};
						bitCnt_nxt  = bitCnt_r + CNT_W'(1);
						if (lastBit) begin
							state_nxt = ST_DONE;
							hold_nxt  = 1'h0;
						end
					end
				end
				ST_DONE: begin
					// Extra clocks shift zeros until select returns high
					if (sclkFall) begin
						dataOut_nxt = 1'h0;
					end
				end
				default: state_nxt = ST_IDLE;
			endcase
		end
	end

	// State registers; reset leaves the port idle and powered down
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r   <= ST_IDLE;
			edgeCnt_r <= 3'h0;
			bitCnt_r  <= '0;
			shift_r   <= CODE_MIN;
			dataOut_r <= 1'h0;
			dataOe_r  <= 1'h0;
			hold_r    <= 1'h0;
		end else begin
			state_r   <= state_nxt;
			edgeCnt_r <= edgeCnt_nxt;
			bitCnt_r  <= bitCnt_nxt;
			shift_r   <= shift_nxt;
			dataOut_r <= dataOut_nxt;
			dataOe_r  <= dataOe_nxt;
			hold_r    <= hold_nxt;
		end
	end

	assign dataOut    = dataOut_r;
	assign dataOe     = dataOe_r;
	assign holdSample = hold_r;
	assign powerDown  = ~hold_r;

	// Enable step: fifth detected fall while waiting, select still low
	sequence s_fifth_fall;
		state_r == ST_WAIT && sclkFall && lastWait && !selRise;
	endsequence

	// Shift step: detected fall while result bits go out
	sequence s_shift_fall;
		state_r == ST_SHIFT && sclkFall && !selRise;
	endsequence

	// Output enabled only after the fifth clock fall
	a_enable_after_fifth: assert property (@(posedge clk) disable iff (!resetn)
		$rose(dataOe) |-> !dataOut && $past(sclkFall) && $past(lastWait)
			&& $past(state_r) == ST_WAIT) else $error("enable not on fifth clock fall");
	a_enable_step: assert property (@(posedge clk) disable iff (!resetn)
		s_fifth_fall |=> dataOe && !dataOut) else $error("output not enabled low");
	a_idle_high_z: assert property (@(posedge clk) disable iff (!resetn)
		selRise |=> !dataOe) else $error("output still driven after select high");
	// Clock falls before a select fall are ignored
	a_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_IDLE && !selFall |=> state_r == ST_IDLE && !dataOe)
		else $error("idle left without select fall");
	a_oe_in_frame: assert property (@(posedge clk) disable iff (!resetn)
		dataOe |-> state_r == ST_SHIFT || state_r == ST_DONE) else $error("output on outside frame");
	a_bit_stable: assert property (@(posedge clk) disable iff (!resetn)
		!sclkFall && !selRise && dataOe |=> $stable(dataOut)) else $error("bit changed off a fall");
	a_power_down: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_DONE || state_r == ST_IDLE |-> powerDown)
		else $error("no power down after conversion");
	a_hold_in_frame: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_WAIT || state_r == ST_SHIFT |-> holdSample && !powerDown)
		else $error("sample not held during conversion");
	a_last_bit: assert property (@(posedge clk) disable iff (!resetn)
		s_shift_fall ##0 lastBit |=> state_r == ST_DONE && powerDown)
		else $error("no power down after last bit");
	a_sample_hold: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_IDLE && selFall |=> holdSample && shift_r == $past(capCode))
		else $error("sample not taken at select fall");
	a_msb_first: assert property (@(posedge clk) disable iff (!resetn)
		s_shift_fall |=> dataOut == $past(shift_r[RESULT_W-1]))
		else $error("bit order wrong");
	// Clocks past the last bit give zeros
	a_trail_zero: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_DONE && sclkFall && !selRise |=> !dataOut) else $error("trailing bit not zero");
	a_saturate_max: assert property (@(posedge clk) disable iff (!resetn)
		sampleIn.over |-> capCode == CODE_MAX) else $error("overrange not saturated");
	a_saturate_min: assert property (@(posedge clk) disable iff (!resetn)
		!sampleIn.over && sampleIn.under |-> capCode == CODE_MIN) else $error("underrange wrong");
endmodule
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host side: drives select and serial clock, samples data on clock rise
module host_model (
	input  wire logic clk,
	output logic      selN,
	output logic      sclk,
	input  wire logic dout,
	input  wire logic oe
);
	// Select idle high, clock stands high outside frames
	initial begin
		selN = 1'b1;
		sclk = 1'b1;
	end
	// One frame of n clock falls, then select released
	// Quarter-nanosecond skew keeps every serial clock edge and the select release off the system clock edges; select falls on a clock fall
	task automatic frame(input int n, output logic [20:0] bits, output logic [20:0] ens);
		@(negedge clk) selN = 1'b0;
		#200.25;
		for (int i = 0; i < n; i++) begin
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
			// Undriven line reads as the inverse of the last driven level
			bits = {bits[19:0], oe ? dout : ~dout};
			ens = {ens[19:0], oe};
		end
		#100 selN = 1'b1;
		#200;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin numChecks++; if ((a) !== (e)) begin errCount++; $display("unexpected %s expected %h seen %h", nm, e, a); end end
module tb;
	import adc_readout_pkg::*;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        selectN, sclk, dataOut, dataOe, holdSample, powerDown;
	sample_t     smp = '0;
	logic [20:0] bits, ens;
	int          errCount = 0, numChecks = 0, cyc = 0;

	always #2 clk = ~clk;

	adc_serial_readout dut (.clk(clk), .resetn(resetn), .selectN(selectN),
		.serial_clock_in(sclk), .sampleIn(smp), .dataOut(dataOut), .dataOe(dataOe),
		.holdSample(holdSample), .powerDown(powerDown));
	host_model host (.clk(clk), .selN(selectN), .sclk(sclk), .dout(dataOut), .oe(dataOe));

	// Hang guard, about three times eight frames of up to 850 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errCount++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Full readout; input changed mid-frame must not leak into the result
	task automatic t_read(input sample_t s, input logic [15:0] exp);
		@(negedge clk) smp = s;
		fork
			host.frame(21, bits, ens);
			begin
				#1000 @(negedge clk) smp = ~s;
				`CHK("hold", 1'b1, holdSample)
				`CHK("awake", 1'b0, powerDown)
			end
		join
		`CHK("enable", 21'h01FFFF, ens)
		`CHK("data", {1'b0, exp}, bits[16:0])
		`CHK("power", 1'b1, powerDown)
		`CHK("release", 1'b0, dataOe)
		$display("read %h done", exp);
	endtask

	// Select raised mid-shift drops the output at once
	task automatic t_abort;
		host.frame(8, bits, ens);
		`CHK("early", 8'h0F, ens[7:0])
		`CHK("abort", 1'b0, dataOe)
		`CHK("abort pd", 1'h1, powerDown)
		$display("abort done");
	endtask

	// Mid-run reset while idle; no false select edge may follow release
	task automatic t_reset;
		@(negedge clk) resetn = 1'h0;
		repeat (12) @(negedge clk);
		`CHK("rst oe", 1'h0, dataOe)
		`CHK("rst hold", 1'h0, holdSample)
		`CHK("rst pd", 1'h1, powerDown)
		resetn = 1'h1;
		repeat (2) @(negedge clk);
		`CHK("post hold", 1'h0, holdSample)
		`CHK("post oe", 1'h0, dataOe)
		repeat (8) @(negedge clk);
		$display("reset done");
	endtask

	// Clocks past the last bit give zeros and keep the output on
	task automatic t_extra;
		@(negedge clk) smp = {1'h0, 1'h0, 16'hFFFF};
		host.frame(23, bits, ens);
		`CHK("tail ens", 21'h07FFFF, ens)
		`CHK("tail data", {1'h0, 16'hFFFF, 2'h0}, bits[18:0])
		`CHK("tail pd", 1'h1, powerDown)
		$display("extra done");
	endtask

	initial begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		repeat (8) @(negedge clk);
		t_read({1'b0, 1'b0, 16'h8001}, 16'h8001);
		t_read({1'b0, 1'b0, 16'h7FFE}, 16'h7FFE);
		t_read({1'b1, 1'b0, 16'h1234}, CODE_MAX);
		t_read({1'b0, 1'b1, 16'h1234}, CODE_MIN);
		t_read({1'b1, 1'b1, 16'h1234}, CODE_MAX);
		t_abort();
		t_reset();
		t_extra();
		t_read({1'b0, 1'b0, 16'hA55A}, 16'hA55A);
		wrap_up();
	end
endmodule
`default_nettype wire
